/* pkg/stop_pkg.sv */
`default_nettype none
package stop_pkg;
	// Object indices seen over the link
	localparam logic [15:0] IDX_QUICK_STOP = 16'h605A;
	localparam logic [15:0] IDX_HALT = 16'h605D;
	localparam logic [15:0] IDX_DISABLE_OP = 16'h605C;
	localparam logic [15:0] IDX_OT_SELECT = 16'h2208;
	localparam logic [15:0] IDX_ESTOP_REQ = 16'h2D06;
	// Reset values
	localparam logic [15:0] RST_QUICK_STOP = 16'h0002;
	localparam logic [15:0] RST_HALT = 16'h0001;
	localparam logic [15:0] RST_DISABLE_OP = 16'h0000;
	localparam logic [15:0] RST_OT_SELECT = 16'h0001;
	localparam logic [15:0] RST_ESTOP_REQ = 16'h0000;
	// Legal ranges
	localparam logic [15:0] OT_MAX = 16'h0007;
	localparam logic [15:0] QS_MAX = 16'h0007;
	localparam logic [15:0] HALT_MIN = 16'h0001;
	localparam logic [15:0] HALT_MAX = 16'h0003;
	localparam logic [15:0] ESTOP_MAX = 16'h0001;
	localparam logic signed [15:0] DIS_MIN = -16'sh0004;
	localparam logic signed [15:0] DIS_MAX = 16'sh0001;
	localparam logic [15:0] OT_IGNORE = 16'h0007;
	localparam logic [15:0] QS_BRAKE_LIMIT = 16'h0004;
	// Control word bits
	localparam int CW_QUICK_STOP_BIT = 2;
	localparam int CW_HALT_BIT = 8;
	// Host APB register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CFG_CMD = 8'h04;
	localparam logic [7:0] OFS_CFG_DATA = 8'h08;
	localparam logic [7:0] OFS_CFG_RESULT = 8'h0C;
	localparam logic [7:0] OFS_LINK_STATUS = 8'h10;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
	// Field positions
	localparam int CTRL_FWD_BIT = 16;
	localparam int CTRL_REV_BIT = 17;
	localparam int CFG_WRITE_BIT = 16;
	localparam int RES_ERR_BIT = 16;
	localparam int RES_BUSY_BIT = 17;
	localparam int IRQ_CFG_DONE = 0;
	localparam int IRQ_STOP_RISE = 1;
	localparam int IRQ_W = 2;
	typedef enum logic [2:0] {
		DEC_NONE = 3'h0,
		DEC_COAST = 3'h1,
		DEC_ZERO_SPEED = 3'h2,
		DEC_RAMP_PROFILE = 3'h3,
		DEC_RAMP_QUICK = 3'h4,
		DEC_RAMP_TORQUE = 3'h5,
		DEC_EMERG_TORQUE = 3'h6,
		DEC_DYN_BRAKE = 3'h7
	} decel_t;
	typedef enum logic [1:0] {
		HOLD_RUN = 2'h0,
		HOLD_DE_ENERGIZED = 2'h1,
		HOLD_POSITION_LOCK = 2'h2,
		HOLD_DYN_BRAKE = 2'h3
	} hold_t;
	typedef enum logic [1:0] {
		MODE_PP = 2'h0,
		MODE_PV = 2'h1,
		MODE_HM = 2'h2,
		MODE_PT = 2'h3
	} op_mode_t;
	typedef enum logic [2:0] {
		PH_IDLE = 3'b001,
		PH_STOPPING = 3'b010,
		PH_HOLDING = 3'b100
	} phase_t;
endpackage
`default_nettype wire

/* pkg/stop_link_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface stop_link_if;
	logic [15:0] control_word;
	logic cmd_fwd;
	logic cmd_rev;
	logic cfg_req;
	logic cfg_write;
	logic [15:0] cfg_index;
	logic [15:0] cfg_wdata;
	logic cfg_ack;
	logic cfg_err;
	logic [15:0] cfg_rdata;
	logic stop_active;
	logic fwd_inhibit;
	logic rev_inhibit;
	modport device (input control_word, cmd_fwd, cmd_rev, cfg_req, cfg_write, cfg_index,
		cfg_wdata, output cfg_ack, cfg_err, cfg_rdata, stop_active, fwd_inhibit, rev_inhibit);
	modport host (output control_word, cmd_fwd, cmd_rev, cfg_req, cfg_write, cfg_index,
		cfg_wdata, input cfg_ack, cfg_err, cfg_rdata, stop_active, fwd_inhibit, rev_inhibit);
endinterface
`default_nettype wire

/* logic/stop_device.sv */
`timescale 1ns/10ps
`default_nettype none
module stop_device (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Link to host
	stop_link_if.device link,
	// Limit switches and stop inputs
	input wire logic positive_limit_input,
	input wire logic negative_limit_input,
	input wire logic panic_stop_input,
	input wire logic input_function_fwd_limit,
	input wire logic input_function_rev_limit,
	input wire logic input_function_panic_stop,
	input wire logic fwd_limit_active_low,
	input wire logic rev_limit_active_low,
	input wire logic panic_active_low,
	// Drive context
	input wire logic brake_output_enable,
	input wire stop_pkg::op_mode_t op_mode,
	input wire logic motor_stopped,
	// Stop outputs
	output stop_pkg::decel_t decel_mode,
	output stop_pkg::hold_t hold_mode,
	output stop_pkg::phase_t phase,
	output logic [3:0] stop_cause
);
	typedef struct packed {
		stop_pkg::decel_t decel;
		stop_pkg::hold_t hold;
	} action_t;

	logic [15:0] quick_stop_option;
	logic [15:0] halt_option;
	logic [15:0] overtravel_stop_select;
	logic [15:0] emergency_stop_request;
	logic [15:0] disable_op_option;
	logic fwd_act, rev_act, panic_act, fwd_blk, rev_blk;
	logic ot_stop, qs_req, halt_req, any_stop;
	logic wr_ok;
	action_t next_action;
	stop_pkg::phase_t next_phase;

	function automatic action_t ot_map(input logic [15:0] code, input logic brake);
		action_t a;
		a = '{stop_pkg::DEC_NONE, stop_pkg::HOLD_RUN};
		if (brake)
			a = '{stop_pkg::DEC_RAMP_QUICK, stop_pkg::HOLD_POSITION_LOCK};
		else
		begin
			case (code[2:0])
				3'h0: a = '{stop_pkg::DEC_COAST, stop_pkg::HOLD_DE_ENERGIZED};
				3'h1: a = '{stop_pkg::DEC_ZERO_SPEED, stop_pkg::HOLD_POSITION_LOCK};
				3'h2: a = '{stop_pkg::DEC_ZERO_SPEED, stop_pkg::HOLD_DE_ENERGIZED};
				3'h3: a = '{stop_pkg::DEC_RAMP_QUICK, stop_pkg::HOLD_DE_ENERGIZED};
				3'h4: a = '{stop_pkg::DEC_RAMP_QUICK, stop_pkg::HOLD_POSITION_LOCK};
				3'h5: a = '{stop_pkg::DEC_DYN_BRAKE, stop_pkg::HOLD_DE_ENERGIZED};
				3'h6: a = '{stop_pkg::DEC_DYN_BRAKE, stop_pkg::HOLD_DYN_BRAKE};
				default: a = '{stop_pkg::DEC_NONE, stop_pkg::HOLD_RUN};
			endcase
		end
		return a;
	endfunction

	function automatic action_t qs_map(input logic [15:0] code, input logic brake);
		action_t a;
		a = '{stop_pkg::DEC_NONE, stop_pkg::HOLD_RUN};
		if (brake && code < stop_pkg::QS_BRAKE_LIMIT)
			a = '{stop_pkg::DEC_RAMP_QUICK, stop_pkg::HOLD_DE_ENERGIZED};
		else
		begin
			case (code[2:0])
				3'h0: a = '{stop_pkg::DEC_COAST, stop_pkg::HOLD_DE_ENERGIZED};
				3'h1: a = '{stop_pkg::DEC_RAMP_PROFILE, stop_pkg::HOLD_DE_ENERGIZED};
				3'h2: a = '{stop_pkg::DEC_RAMP_QUICK, stop_pkg::HOLD_DE_ENERGIZED};
				3'h3: a = '{stop_pkg::DEC_EMERG_TORQUE, stop_pkg::HOLD_DE_ENERGIZED};
				3'h5: a = '{stop_pkg::DEC_RAMP_PROFILE, stop_pkg::HOLD_POSITION_LOCK};
				3'h6: a = '{stop_pkg::DEC_RAMP_QUICK, stop_pkg::HOLD_POSITION_LOCK};
				3'h7: a = '{stop_pkg::DEC_EMERG_TORQUE, stop_pkg::HOLD_POSITION_LOCK};
				// Code 4 has no stop of its own; fall back to a quick ramp to stay safe
				default: a = '{stop_pkg::DEC_RAMP_QUICK, stop_pkg::HOLD_DE_ENERGIZED};
			endcase
		end
		return a;
	endfunction

	function automatic action_t dis_map(input logic [15:0] code);
		action_t a;
		a = '{stop_pkg::DEC_NONE, stop_pkg::HOLD_RUN};
		case (code)
			16'hFFFC: a = '{stop_pkg::DEC_RAMP_QUICK, stop_pkg::HOLD_DYN_BRAKE};
			16'hFFFD: a = '{stop_pkg::DEC_ZERO_SPEED, stop_pkg::HOLD_DYN_BRAKE};
			16'hFFFE: a = '{stop_pkg::DEC_RAMP_PROFILE, stop_pkg::HOLD_DYN_BRAKE};
			16'hFFFF: a = '{stop_pkg::DEC_DYN_BRAKE, stop_pkg::HOLD_DYN_BRAKE};
			16'h0001: a = '{stop_pkg::DEC_RAMP_PROFILE, stop_pkg::HOLD_DE_ENERGIZED};
			default: a = '{stop_pkg::DEC_COAST, stop_pkg::HOLD_DE_ENERGIZED};
		endcase
		return a;
	endfunction

	function automatic action_t halt_map(input logic [15:0] code, input stop_pkg::op_mode_t m);
		action_t a;
		a = '{stop_pkg::DEC_RAMP_PROFILE, stop_pkg::HOLD_POSITION_LOCK};
		if (m == stop_pkg::MODE_PT)
			a = '{stop_pkg::DEC_RAMP_TORQUE, stop_pkg::HOLD_POSITION_LOCK};
		else
		begin
			case (code[1:0])
				2'h2: a = '{stop_pkg::DEC_RAMP_QUICK, stop_pkg::HOLD_POSITION_LOCK};
				2'h3: a = '{stop_pkg::DEC_EMERG_TORQUE, stop_pkg::HOLD_POSITION_LOCK};
				default: a = '{stop_pkg::DEC_RAMP_PROFILE, stop_pkg::HOLD_POSITION_LOCK};
			endcase
		end
		return a;
	endfunction

	// Level-driven limit sensing, polarity per input
	assign fwd_act = input_function_fwd_limit && (positive_limit_input ^ fwd_limit_active_low);
	assign rev_act = input_function_rev_limit && (negative_limit_input ^ rev_limit_active_low);
	assign panic_act = input_function_panic_stop && (panic_stop_input ^ panic_active_low);
	assign fwd_blk = fwd_act && (overtravel_stop_select != stop_pkg::OT_IGNORE);
	assign rev_blk = rev_act && (overtravel_stop_select != stop_pkg::OT_IGNORE);
	// A command heading away from the tripped limit releases the stop
	assign ot_stop = (fwd_blk && !link.cmd_rev) || (rev_blk && !link.cmd_fwd);
	assign qs_req = !link.control_word[stop_pkg::CW_QUICK_STOP_BIT];
	assign halt_req = link.control_word[stop_pkg::CW_HALT_BIT];
	assign any_stop = panic_act || emergency_stop_request[0] || ot_stop || qs_req || halt_req;

	// Severity order: panic, stop parameter, overtravel, quick stop, halt
	always_comb
	begin
		next_action = '{stop_pkg::DEC_NONE, stop_pkg::HOLD_RUN};
		if (panic_act)
			next_action = qs_map(quick_stop_option, brake_output_enable);
		else if (emergency_stop_request[0])
			next_action = dis_map(disable_op_option);
		else if (ot_stop)
			next_action = ot_map(overtravel_stop_select, brake_output_enable);
		else if (qs_req)
			next_action = qs_map(quick_stop_option, brake_output_enable);
		else if (halt_req)
			next_action = halt_map(halt_option, op_mode);
	end

	always_comb
	begin
		next_phase = phase;
		case (phase)
			stop_pkg::PH_IDLE: if (any_stop) next_phase = stop_pkg::PH_STOPPING;
			stop_pkg::PH_STOPPING: if (!any_stop) next_phase = stop_pkg::PH_IDLE;
				else if (motor_stopped) next_phase = stop_pkg::PH_HOLDING;
			stop_pkg::PH_HOLDING: if (!any_stop) next_phase = stop_pkg::PH_IDLE;
			default: next_phase = stop_pkg::PH_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			phase <= stop_pkg::PH_IDLE;
			decel_mode <= stop_pkg::DEC_NONE;
			hold_mode <= stop_pkg::HOLD_RUN;
			stop_cause <= 4'h0;
			link.stop_active <= 1'b0;
			link.fwd_inhibit <= 1'b0;
			link.rev_inhibit <= 1'b0;
		end
		else
		begin
			phase <= next_phase;
			decel_mode <= next_action.decel;
			hold_mode <= next_action.hold;
			stop_cause <= {panic_act | emergency_stop_request[0], ot_stop, qs_req, halt_req};
			link.stop_active <= any_stop;
			link.fwd_inhibit <= fwd_blk;
			link.rev_inhibit <= rev_blk;
		end
	end

	// Writes outside an object's range are refused and leave it unchanged
	always_comb
	begin
		wr_ok = 1'b0;
		case (link.cfg_index)
			stop_pkg::IDX_QUICK_STOP: wr_ok = link.cfg_wdata <= stop_pkg::QS_MAX;
			stop_pkg::IDX_HALT: wr_ok = link.cfg_wdata >= stop_pkg::HALT_MIN
				&& link.cfg_wdata <= stop_pkg::HALT_MAX;
			stop_pkg::IDX_OT_SELECT: wr_ok = link.cfg_wdata <= stop_pkg::OT_MAX;
			stop_pkg::IDX_ESTOP_REQ: wr_ok = link.cfg_wdata <= stop_pkg::ESTOP_MAX;
			stop_pkg::IDX_DISABLE_OP: wr_ok = $signed(link.cfg_wdata) >= stop_pkg::DIS_MIN
				&& $signed(link.cfg_wdata) <= stop_pkg::DIS_MAX;
			default: wr_ok = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			quick_stop_option <= stop_pkg::RST_QUICK_STOP;
			halt_option <= stop_pkg::RST_HALT;
			overtravel_stop_select <= stop_pkg::RST_OT_SELECT;
			emergency_stop_request <= stop_pkg::RST_ESTOP_REQ;
			disable_op_option <= stop_pkg::RST_DISABLE_OP;
		end
		else if (link.cfg_req && link.cfg_write && wr_ok)
		begin
			case (link.cfg_index)
				stop_pkg::IDX_QUICK_STOP: quick_stop_option <= link.cfg_wdata;
				stop_pkg::IDX_HALT: halt_option <= link.cfg_wdata;
				stop_pkg::IDX_OT_SELECT: overtravel_stop_select <= link.cfg_wdata;
				stop_pkg::IDX_ESTOP_REQ: emergency_stop_request <= link.cfg_wdata;
				stop_pkg::IDX_DISABLE_OP: disable_op_option <= link.cfg_wdata;
				default: disable_op_option <= disable_op_option;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			link.cfg_ack <= 1'b0;
			link.cfg_err <= 1'b0;
			link.cfg_rdata <= 16'h0000;
		end
		else
		begin
			link.cfg_ack <= link.cfg_req;
			if (link.cfg_req)
			begin
				link.cfg_err <= link.cfg_write ? !wr_ok : 1'b0;
				case (link.cfg_index)
					stop_pkg::IDX_QUICK_STOP: link.cfg_rdata <= quick_stop_option;
					stop_pkg::IDX_HALT: link.cfg_rdata <= halt_option;
					stop_pkg::IDX_OT_SELECT: link.cfg_rdata <= overtravel_stop_select;
					stop_pkg::IDX_ESTOP_REQ: link.cfg_rdata <= emergency_stop_request;
					stop_pkg::IDX_DISABLE_OP: link.cfg_rdata <= disable_op_option;
					default:
					begin
						link.cfg_rdata <= 16'h0000;
						link.cfg_err <= 1'b1;
					end
				endcase
			end
		end
	end
endmodule
`default_nettype wire

/* logic/stop_host.sv */
`timescale 1ns/10ps
`default_nettype none
module stop_host (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Interrupt
	output logic irq,
	// Link to drive
	stop_link_if.host link
);
	logic [31:0] cfg_cmd;
	logic [15:0] cfg_data;
	logic [15:0] res_data;
	logic res_err;
	logic busy;
	logic stop_seen;
	logic [stop_pkg::IRQ_W-1:0] irq_status;
	logic [stop_pkg::IRQ_W-1:0] irq_mask;
	logic [stop_pkg::IRQ_W-1:0] irq_set;
	logic access, wr_now, mapped;
	logic [31:0] rd_mux;

	// One wait state so read data comes from a flop
	assign access = psel && penable;
	assign wr_now = access && pready && pwrite;
	assign mapped = paddr <= stop_pkg::OFS_IRQ_MASK && paddr[1:0] == 2'h0;
	assign irq_set = {link.stop_active && !stop_seen, link.cfg_ack};

	always_comb
	begin
		rd_mux = 32'h00000000;
		case (paddr)
			stop_pkg::OFS_CTRL: rd_mux = {14'h0000, link.cmd_rev, link.cmd_fwd, link.control_word};
			stop_pkg::OFS_CFG_CMD: rd_mux = cfg_cmd;
			stop_pkg::OFS_CFG_DATA: rd_mux = {16'h0000, cfg_data};
			stop_pkg::OFS_CFG_RESULT: rd_mux = {14'h0000, busy, res_err, res_data};
			stop_pkg::OFS_LINK_STATUS: rd_mux = {29'h00000000, link.rev_inhibit,
				link.fwd_inhibit, link.stop_active};
			stop_pkg::OFS_IRQ_STATUS: rd_mux = {30'h00000000, irq_status};
			stop_pkg::OFS_IRQ_MASK: rd_mux = {30'h00000000, irq_mask};
			default: rd_mux = 32'h00000000;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= access && !pready;
			if (access && !pready)
			begin
				prdata <= pwrite ? 32'h00000000 : rd_mux;
				pslverr <= !mapped;
			end
		end
	end

	// Host command lines; control word resets with quick stop released
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			link.control_word <= 16'h0004;
			link.cmd_fwd <= 1'b0;
			link.cmd_rev <= 1'b0;
			cfg_cmd <= 32'h00000000;
			cfg_data <= 16'h0000;
			irq_mask <= '0;
		end
		else if (wr_now)
		begin
			case (paddr)
				stop_pkg::OFS_CTRL:
				begin
					link.control_word <= pwdata[15:0];
					link.cmd_fwd <= pwdata[stop_pkg::CTRL_FWD_BIT];
					link.cmd_rev <= pwdata[stop_pkg::CTRL_REV_BIT];
				end
				stop_pkg::OFS_CFG_CMD: if (!busy) cfg_cmd <= {15'h0000, pwdata[16:0]};
				stop_pkg::OFS_CFG_DATA: cfg_data <= pwdata[15:0];
				stop_pkg::OFS_IRQ_MASK: irq_mask <= pwdata[stop_pkg::IRQ_W-1:0];
				default: cfg_data <= cfg_data;
			endcase
		end
	end

	// Object transfer: one request pulse, wait for the acknowledge
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			busy <= 1'b0;
			link.cfg_req <= 1'b0;
			link.cfg_write <= 1'b0;
			link.cfg_index <= 16'h0000;
			link.cfg_wdata <= 16'h0000;
			res_data <= 16'h0000;
			res_err <= 1'b0;
		end
		else
		begin
			link.cfg_req <= 1'b0;
			if (wr_now && paddr == stop_pkg::OFS_CFG_CMD && !busy)
			begin
				busy <= 1'b1;
				link.cfg_req <= 1'b1;
				link.cfg_write <= pwdata[stop_pkg::CFG_WRITE_BIT];
				link.cfg_index <= pwdata[15:0];
				link.cfg_wdata <= cfg_data;
			end
			else if (link.cfg_ack)
			begin
				busy <= 1'b0;
				res_data <= link.cfg_rdata;
				res_err <= link.cfg_err;
			end
		end
	end

	// Set beats clear when both land in the same cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_status <= '0;
			stop_seen <= 1'b0;
			irq <= 1'b0;
		end
		else
		begin
			stop_seen <= link.stop_active;
			if (wr_now && paddr == stop_pkg::OFS_IRQ_STATUS)
				irq_status <= (irq_status & ~pwdata[stop_pkg::IRQ_W-1:0]) | irq_set;
			else
				irq_status <= irq_status | irq_set;
			irq <= |(irq_status & irq_mask);
		end
	end
endmodule
`default_nettype wire

/* sim/stop_link_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module stop_link_sva (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Host to device
	input wire logic [15:0] control_word,
	input wire logic cmd_fwd,
	input wire logic cmd_rev,
	input wire logic cfg_req,
	input wire logic cfg_write,
	input wire logic [15:0] cfg_index,
	input wire logic [15:0] cfg_wdata,
	// Device to host
	input wire logic cfg_ack,
	input wire logic cfg_err,
	input wire logic [15:0] cfg_rdata,
	input wire logic stop_active,
	input wire logic fwd_inhibit,
	input wire logic rev_inhibit
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic wr;
	logic known;
	assign wr = cfg_req && cfg_write;
	assign known = cfg_index inside {stop_pkg::IDX_QUICK_STOP, stop_pkg::IDX_HALT,
		stop_pkg::IDX_DISABLE_OP, stop_pkg::IDX_OT_SELECT, stop_pkg::IDX_ESTOP_REQ};
	a_ack_pulse: assert property (cfg_req |=> cfg_ack ##1 !cfg_ack)
		else $error("cfg_ack is not one pulse one cycle after cfg_req");
	a_ack_has_req: assert property (cfg_ack |-> $past(cfg_req))
		else $error("cfg_ack without request");
	// Software may read the result late, so only an answer may refresh it
	a_result_holds: assert property (!cfg_ack |-> $stable(cfg_rdata) && $stable(cfg_err))
		else $error("result changed without cfg_ack");
	a_ot_range: assert property (
		wr && cfg_index == stop_pkg::IDX_OT_SELECT && cfg_wdata > stop_pkg::OT_MAX |=> cfg_err)
		else $error("overtravel code above range accepted");
	a_qs_range: assert property (
		wr && cfg_index == stop_pkg::IDX_QUICK_STOP && cfg_wdata > stop_pkg::QS_MAX |=> cfg_err)
		else $error("quick-stop code above range accepted");
	a_halt_range: assert property (wr && cfg_index == stop_pkg::IDX_HALT &&
		(cfg_wdata < stop_pkg::HALT_MIN || cfg_wdata > stop_pkg::HALT_MAX) |=> cfg_err)
		else $error("halt code out of range accepted");
	a_estop_range: assert property (
		wr && cfg_index == stop_pkg::IDX_ESTOP_REQ && cfg_wdata > stop_pkg::ESTOP_MAX |=> cfg_err)
		else $error("stop request value above range accepted");
	a_unknown_index: assert property (cfg_req && !known |=> cfg_err && cfg_rdata == 16'h0000)
		else $error("unknown index not refused");
	a_quick_stop_req: assert property (!control_word[2] |=> stop_active)
		else $error("quick stop bit low without stop");
	a_halt_req: assert property (control_word[8] |=> stop_active)
		else $error("halt bit high without stop");
	a_fwd_overtravel: assert property ((fwd_inhibit && !cmd_rev) [*2] |-> stop_active)
		else $error("forward limit without stop");
	a_rev_overtravel: assert property ((rev_inhibit && !cmd_fwd) [*2] |-> stop_active)
		else $error("reverse limit without stop");
	c_cfg_error: cover property (cfg_ack && cfg_err);
	c_stop_rise: cover property ($rose(stop_active));
	c_back_out: cover property (fwd_inhibit && cmd_rev);
	c_rev_limit: cover property (rev_inhibit);
endmodule
`default_nettype wire

/* sim/motion_stop_mode_control_test.sv */
`timescale 1ns/10ps
`default_nettype none
module motion_stop_mode_control_test;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, bus_err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic positive_limit_input, negative_limit_input, panic_stop_input;
	logic input_function_fwd_limit, input_function_rev_limit, input_function_panic_stop;
	logic fwd_limit_active_low, rev_limit_active_low, panic_active_low;
	logic brake_output_enable, motor_stopped;
	stop_pkg::op_mode_t op_mode;
	stop_pkg::decel_t decel_mode;
	stop_pkg::hold_t hold_mode;
	stop_pkg::phase_t phase;
	logic [3:0] stop_cause;
	int error_cnt, n_compared;
	// Expected {decel_mode, hold_mode} per code, packed from the package encodings
	logic [4:0] qs_tab [8] = '{5'h05, 5'h0D, 5'h11, 5'h19, 5'h11, 5'h0E, 5'h12, 5'h1A};
	logic [4:0] ot_tab [7] = '{5'h05, 5'h0A, 5'h09, 5'h11, 5'h12, 5'h1D, 5'h1F};
	logic [4:0] halt_tab [4] = '{5'h00, 5'h0E, 5'h12, 5'h1A};
	stop_link_if link ();
	stop_host stop_host_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .irq, .link(link.host));
	stop_device stop_device_inst (.pclk, .presetn, .link(link.device), .positive_limit_input,
		.negative_limit_input, .panic_stop_input, .input_function_fwd_limit,
		.input_function_rev_limit, .input_function_panic_stop, .fwd_limit_active_low,
		.rev_limit_active_low, .panic_active_low, .brake_output_enable, .op_mode,
		.motor_stopped, .decel_mode, .hold_mode, .phase, .stop_cause);
	stop_link_sva stop_link_sva_inst (.pclk, .presetn, .control_word(link.control_word),
		.cmd_fwd(link.cmd_fwd), .cmd_rev(link.cmd_rev), .cfg_req(link.cfg_req),
		.cfg_write(link.cfg_write), .cfg_index(link.cfg_index), .cfg_wdata(link.cfg_wdata),
		.cfg_ack(link.cfg_ack), .cfg_err(link.cfg_err), .cfg_rdata(link.cfg_rdata),
		.stop_active(link.stop_active), .fwd_inhibit(link.fwd_inhibit),
		.rev_inhibit(link.rev_inhibit));
	initial
	begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	task automatic final_report();
		if (error_cnt == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_compared++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[ERR] %0t %s: got %h want %h", $time, what, got, exp);
		end
	endtask
	// An idle cycle always precedes setup, so no strobe is driven twice in one step
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		rd = prdata;
		bus_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 16)
		begin
			cmp(32'h0, 32'h1, "APB answer missing");
			final_report();
		end
	endtask
	task automatic ctrl(input logic [17:0] v);
		apb(1'b1, stop_pkg::OFS_CTRL, {14'h0000, v});
	endtask
	task automatic cfg(input logic w, input logic [15:0] idx, input logic [15:0] d,
		input logic err, input logic [15:0] exp);
		int n;
		apb(1'b1, stop_pkg::OFS_CFG_DATA, {16'h0000, d});
		apb(1'b1, stop_pkg::OFS_CFG_CMD, {15'h0000, w, idx});
		n = 0;
		do
		begin
			apb(1'b0, stop_pkg::OFS_CFG_RESULT, 32'h0);
			n++;
		end
		while (rd[17] !== 1'b0 && n < 8);
		cmp({13'h0000, bus_err, rd[17:0]}, {13'h0000, 2'b00, err, exp}, "object access");
		if (n >= 8)
			final_report();
	endtask
	task automatic chk(input logic [4:0] exp, input logic [3:0] cause);
		repeat (3) @(posedge pclk);
		cmp({27'h0, decel_mode, hold_mode}, {27'h0, exp}, "decel and hold");
		cmp({28'h0, stop_cause}, {28'h0, cause}, "stop cause");
	endtask
	task automatic t_defaults();
		cmp({29'h0, phase}, {29'h0, stop_pkg::PH_IDLE}, "reset phase");
		cfg(1'b0, stop_pkg::IDX_QUICK_STOP, 16'h0, 1'b0, 16'h0002);
		cfg(1'b0, stop_pkg::IDX_HALT, 16'h0, 1'b0, 16'h0001);
		cfg(1'b0, stop_pkg::IDX_OT_SELECT, 16'h0, 1'b0, 16'h0001);
		cfg(1'b0, stop_pkg::IDX_ESTOP_REQ, 16'h0, 1'b0, 16'h0000);
		cfg(1'b1, stop_pkg::IDX_OT_SELECT, 16'h0008, 1'b1, 16'h0001);
		cfg(1'b1, stop_pkg::IDX_QUICK_STOP, 16'h0008, 1'b1, 16'h0002);
		cfg(1'b1, stop_pkg::IDX_HALT, 16'h0000, 1'b1, 16'h0001);
		cfg(1'b1, stop_pkg::IDX_HALT, 16'h0004, 1'b1, 16'h0001);
		cfg(1'b1, stop_pkg::IDX_ESTOP_REQ, 16'h0002, 1'b1, 16'h0000);
		cfg(1'b0, 16'h1234, 16'h0, 1'b1, 16'h0000);
		apb(1'b0, 8'h1C, 32'h0);
		cmp({31'h0, bus_err}, 32'h1, "unmapped access");
	endtask
	task automatic t_quick_stop();
		for (int c = 0; c < 8; c++)
		begin
			cfg(1'b1, stop_pkg::IDX_QUICK_STOP, 16'(c), 1'b0, 16'(c ? c - 1 : 2));
			ctrl(18'h00000);
			chk(qs_tab[c], 4'b0010);
			motor_stopped <= 1'b1;
			chk(qs_tab[c], 4'b0010);
			cmp({29'h0, phase}, {29'h0, stop_pkg::PH_HOLDING}, "holding phase");
			motor_stopped <= 1'b0;
			ctrl(18'h00004);
			chk(5'h00, 4'b0000);
		end
		brake_output_enable <= 1'b1;
		ctrl(18'h00000);
		chk(5'h1A, 4'b0010);
		cfg(1'b1, stop_pkg::IDX_QUICK_STOP, 16'h0000, 1'b0, 16'h0007);
		chk(5'h11, 4'b0010);
		cfg(1'b1, stop_pkg::IDX_QUICK_STOP, 16'h0002, 1'b0, 16'h0000);
		brake_output_enable <= 1'b0;
		ctrl(18'h00004);
	endtask
	task automatic t_halt();
		for (int h = 1; h < 4; h++)
		begin
			cfg(1'b1, stop_pkg::IDX_HALT, 16'(h), 1'b0, 16'(h > 1 ? h - 1 : 1));
			op_mode <= stop_pkg::op_mode_t'(h - 1);
			ctrl(18'h00104);
			chk(halt_tab[h], 4'b0001);
		end
		op_mode <= stop_pkg::MODE_PT;
		chk(5'h16, 4'b0001);
		op_mode <= stop_pkg::MODE_PP;
		ctrl(18'h00100);
		chk(5'h11, 4'b0011);
		ctrl(18'h00004);
		chk(5'h00, 4'b0000);
	endtask
	task automatic t_overtravel();
		for (int c = 0; c < 7; c++)
		begin
			cfg(1'b1, stop_pkg::IDX_OT_SELECT, 16'(c), 1'b0, 16'(c ? c - 1 : 1));
			positive_limit_input <= 1'b1;
			chk(ot_tab[c], 4'b0100);
			positive_limit_input <= 1'b0;
			chk(5'h00, 4'b0000);
		end
		positive_limit_input <= 1'b1;
		apb(1'b0, stop_pkg::OFS_LINK_STATUS, 32'h0);
		cmp(rd, 32'h3, "forward inhibit status");
		ctrl(18'h20004);
		chk(5'h00, 4'b0000);
		ctrl(18'h10004);
		chk(5'h1F, 4'b0100);
		brake_output_enable <= 1'b1;
		chk(5'h12, 4'b0100);
		brake_output_enable <= 1'b0;
		positive_limit_input <= 1'b0;
		rev_limit_active_low <= 1'b1;
		ctrl(18'h00004);
		chk(5'h1F, 4'b0100);
		apb(1'b0, stop_pkg::OFS_LINK_STATUS, 32'h0);
		cmp(rd, 32'h5, "reverse inhibit status");
		negative_limit_input <= 1'b1;
		input_function_fwd_limit <= 1'b0;
		positive_limit_input <= 1'b1;
		chk(5'h00, 4'b0000);
		input_function_fwd_limit <= 1'b1;
		cfg(1'b1, stop_pkg::IDX_OT_SELECT, 16'h0007, 1'b0, 16'h0006);
		chk(5'h00, 4'b0000);
		apb(1'b0, stop_pkg::OFS_LINK_STATUS, 32'h0);
		cmp(rd, 32'h0, "code 7 leaves limits alone");
		positive_limit_input <= 1'b0;
		cfg(1'b1, stop_pkg::IDX_OT_SELECT, 16'h0001, 1'b0, 16'h0007);
		ctrl(18'h00004);
	endtask
	task automatic t_panic();
		panic_stop_input <= 1'b1;
		chk(5'h11, 4'b1000);
		ctrl(18'h00104);
		chk(5'h11, 4'b1001);
		panic_stop_input <= 1'b0;
		chk(5'h1A, 4'b0001);
		ctrl(18'h00004);
		cfg(1'b1, stop_pkg::IDX_ESTOP_REQ, 16'h0001, 1'b0, 16'h0000);
		chk(5'h05, 4'b1000);
		cfg(1'b1, stop_pkg::IDX_DISABLE_OP, 16'hFFFC, 1'b0, 16'h0000);
		chk(5'h13, 4'b1000);
		cfg(1'b1, stop_pkg::IDX_ESTOP_REQ, 16'h0000, 1'b0, 16'h0001);
		chk(5'h00, 4'b0000);
	endtask
	task automatic t_irq();
		apb(1'b1, stop_pkg::OFS_IRQ_MASK, 32'h0);
		apb(1'b1, stop_pkg::OFS_IRQ_STATUS, 32'h3);
		cfg(1'b0, stop_pkg::IDX_QUICK_STOP, 16'h0, 1'b0, 16'h0002);
		apb(1'b0, stop_pkg::OFS_IRQ_STATUS, 32'h0);
		cmp({rd[30:0], irq}, 32'h2, "masked done event");
		apb(1'b1, stop_pkg::OFS_IRQ_MASK, 32'h1);
		apb(1'b0, stop_pkg::OFS_IRQ_STATUS, 32'h0);
		cmp({rd[30:0], irq}, 32'h3, "unmasked done event");
		apb(1'b1, stop_pkg::OFS_IRQ_STATUS, 32'h1);
		apb(1'b0, stop_pkg::OFS_IRQ_STATUS, 32'h0);
		cmp({rd[31:1], irq}, 32'h0, "done event cleared");
		apb(1'b1, stop_pkg::OFS_IRQ_MASK, 32'h2);
		ctrl(18'h00000);
		chk(5'h11, 4'b0010);
		// Interrupt trails the stop rise by two flop stages, irq_status then irq
		@(posedge pclk);
		cmp({31'h0, irq}, 32'h1, "stop event interrupt");
		ctrl(18'h00004);
		apb(1'b1, stop_pkg::OFS_IRQ_STATUS, 32'h2);
		apb(1'b0, stop_pkg::OFS_IRQ_STATUS, 32'h0);
		cmp({rd[31:1], irq}, 32'h0, "stop event cleared");
	endtask
	initial
	begin
		{presetn, psel, penable, pwrite} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		{positive_limit_input, negative_limit_input, panic_stop_input, input_function_fwd_limit,
			input_function_rev_limit, input_function_panic_stop, fwd_limit_active_low,
			rev_limit_active_low, panic_active_low, brake_output_enable,
			motor_stopped} = 11'b00011100000;
		op_mode = stop_pkg::MODE_PP;
		error_cnt = 0;
		n_compared = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_defaults();
		t_quick_stop();
		t_halt();
		t_overtravel();
		t_panic();
		t_irq();
		final_report();
	end
endmodule
`default_nettype wire
